// *** core/dpbr_pkg.sv ***
package dpbr_pkg;

    // Word width and depth of the full array (1024 x 36 = 36Kb).
    localparam int DPBR_DATA_W = 36;
    localparam int DPBR_ADDR_W = 10;
    localparam int DPBR_DEPTH  = 1024;

    // Local address width plus one bit that picks the neighbour in a cascade.
    localparam int DPBR_PADDR_W = DPBR_ADDR_W + 1;
    localparam int DPBR_CAS_BIT = DPBR_ADDR_W;

    // In split mode this array bit is forced to the port's own half.
    localparam int DPBR_HALF_BIT = DPBR_ADDR_W - 1;

    localparam logic [DPBR_DATA_W-1:0]  DPBR_DATA_RST = 36'h0;
    localparam logic [DPBR_PADDR_W-1:0] DPBR_ADDR_RST = 11'h0;

    typedef enum logic [1:0] {
        DPBR_WM_READ_FIRST  = 2'b00,
        DPBR_WM_WRITE_FIRST = 2'b01,
        DPBR_WM_NO_CHANGE   = 2'b10
    } dpbr_wmode_t;

endpackage : dpbr_pkg

// *** core/dpbr_mem_if.sv ***
`timescale 1ns/1ps
`default_nettype none

interface dpbr_mem_if;
    import dpbr_pkg::*;

    logic                   req_en;
    logic                   req_we;
    logic [DPBR_ADDR_W-1:0] req_addr;
    logic [DPBR_DATA_W-1:0] req_din;
    logic [DPBR_DATA_W-1:0] rd_data;

    modport port_side (
        output req_en,
        output req_we,
        output req_addr,
        output req_din,
        input  rd_data
    );

    modport array_side (
        input  req_en,
        input  req_we,
        input  req_addr,
        input  req_din,
        output rd_data
    );

endinterface : dpbr_mem_if

`default_nettype wire

// *** core/dpbr_port.sv ***
`timescale 1ns/1ps
`default_nettype none

module dpbr_port #(
    parameter logic PORT_HALF = 1'b0
) (
    input  wire logic                          i_clk,
    input  wire logic                          i_reset,
    input  wire logic                          i_en,
    input  wire logic                          i_we,
    input  wire logic [dpbr_pkg::DPBR_PADDR_W-1:0] i_addr,
    input  wire logic [dpbr_pkg::DPBR_DATA_W-1:0]  i_din,
    input  wire logic                          i_addr_latch,
    input  wire logic                          i_out_reg,
    input  wire dpbr_pkg::dpbr_wmode_t         i_wmode,
    input  wire logic                          i_split,
    input  wire logic                          i_cas_en,
    input  wire logic                          i_sleep,
    input  wire logic [dpbr_pkg::DPBR_DATA_W-1:0]  i_cas_din,
    output logic      [dpbr_pkg::DPBR_DATA_W-1:0]  o_dout,
    output logic      [dpbr_pkg::DPBR_DATA_W-1:0]  o_cas_dout,
    dpbr_mem_if.port_side                      mem
);
    import dpbr_pkg::*;

    typedef struct packed {
        logic                    en;
        logic                    we;
        logic [DPBR_PADDR_W-1:0] addr;
        logic [DPBR_DATA_W-1:0]  din;
        logic [DPBR_DATA_W-1:0]  local_q;
        logic [DPBR_DATA_W-1:0]  dout_q;
        logic [DPBR_DATA_W-1:0]  pipe_q;
    } dpbr_port_state_t;

    dpbr_port_state_t state_reg;
    dpbr_port_state_t state_next;
    logic             hit_local;
    logic             hit_remote;

    // A cascade access to the neighbour leaves this array untouched.
    assign hit_local  = state_reg.en & ~(i_cas_en & state_reg.addr[DPBR_CAS_BIT]);
    assign hit_remote = state_reg.en & i_cas_en & state_reg.addr[DPBR_CAS_BIT];

    always_comb begin
        state_next = state_reg;
        // Enable, write enable and data in are captured every edge; a sleeping array accepts no access.
        state_next.en  = i_en & ~i_sleep;
        state_next.we  = i_we;
        state_next.din = i_din;
        if (i_addr_latch) begin
            state_next.addr = i_addr;
        end
        // Read data changes only on an access, so it holds until the next operation.
        if (hit_local) begin
            if (!state_reg.we) begin
                state_next.local_q = mem.rd_data;
                state_next.dout_q  = mem.rd_data;
            end else if (i_wmode == DPBR_WM_READ_FIRST) begin
                state_next.local_q = mem.rd_data;
                state_next.dout_q  = mem.rd_data;
            end else if (i_wmode == DPBR_WM_WRITE_FIRST) begin
                state_next.local_q = state_reg.din;
                state_next.dout_q  = state_reg.din;
            end
        end else if (hit_remote) begin
            // The neighbour word is taken only at the access edge, never while idle.
            state_next.dout_q = i_cas_din;
        end
        state_next.pipe_q = state_reg.dout_q;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            state_reg <= '{en: 1'b0, we: 1'b0, addr: DPBR_ADDR_RST, din: DPBR_DATA_RST,
                           local_q: DPBR_DATA_RST, dout_q: DPBR_DATA_RST,
                           pipe_q: DPBR_DATA_RST};
        end else begin
            state_reg <= state_next;
        end
    end

    assign mem.req_en   = hit_local;
    assign mem.req_we   = state_reg.we;
    assign mem.req_din  = state_reg.din;
    // In split mode each port owns one half of the array.
    assign mem.req_addr = i_split
        ? {PORT_HALF, state_reg.addr[DPBR_HALF_BIT-1:0]}
        : state_reg.addr[DPBR_ADDR_W-1:0];

    assign o_dout     = i_out_reg ? state_reg.pipe_q : state_reg.dout_q;
    assign o_cas_dout = state_reg.local_q;

endmodule : dpbr_port

`default_nettype wire

// *** core/dpbr_top.sv ***
`timescale 1ns/1ps
`default_nettype none

// Function
// - Two ports run independently and share nothing but the stored words.
// - The array works as one 36Kb memory or as two independent 18Kb halves.
// - Every read and write happens on the clock edge.
// - Enable, write enable, address and data in are captured in registers.
// - The address is registered each edge unless latching is off, and read data holds.
// - An optional output register delays read data by one more cycle.
// - During a write the output shows old data, new data, or stays unchanged.
// - Cascade connections join vertically adjacent instances into deeper arrays.
// - A dedicated input controls dynamic power gating of the instance.
module dpbr_top (
    input  wire logic                              i_clk,
    input  wire logic                              i_reset,
    input  wire logic                              i_split,
    input  wire logic                              i_sleep,
    input  wire logic                              i_a_en,
    input  wire logic                              i_a_we,
    input  wire logic [dpbr_pkg::DPBR_PADDR_W-1:0] i_a_addr,
    input  wire logic [dpbr_pkg::DPBR_DATA_W-1:0]  i_a_din,
    input  wire logic                              i_a_addr_latch,
    input  wire logic                              i_a_out_reg,
    input  wire dpbr_pkg::dpbr_wmode_t             i_a_wmode,
    input  wire logic                              i_a_cas_en,
    input  wire logic [dpbr_pkg::DPBR_DATA_W-1:0]  i_a_cas_din,
    output logic      [dpbr_pkg::DPBR_DATA_W-1:0]  o_a_dout,
    output logic      [dpbr_pkg::DPBR_DATA_W-1:0]  o_a_cas_dout,
    input  wire logic                              i_b_en,
    input  wire logic                              i_b_we,
    input  wire logic [dpbr_pkg::DPBR_PADDR_W-1:0] i_b_addr,
    input  wire logic [dpbr_pkg::DPBR_DATA_W-1:0]  i_b_din,
    input  wire logic                              i_b_addr_latch,
    input  wire logic                              i_b_out_reg,
    input  wire dpbr_pkg::dpbr_wmode_t             i_b_wmode,
    input  wire logic                              i_b_cas_en,
    input  wire logic [dpbr_pkg::DPBR_DATA_W-1:0]  i_b_cas_din,
    output logic      [dpbr_pkg::DPBR_DATA_W-1:0]  o_b_dout,
    output logic      [dpbr_pkg::DPBR_DATA_W-1:0]  o_b_cas_dout
);
    import dpbr_pkg::*;

    dpbr_mem_if mem_a ();
    dpbr_mem_if mem_b ();

    // The stored words are the only resource the two ports share.
    logic [DPBR_DATA_W-1:0] store [DPBR_DEPTH];

    // Port A owns the lower half and port B the upper half when split.
    dpbr_port #(
        .PORT_HALF (1'b0)
    ) u_port_a (
        .i_clk        (i_clk),
        .i_reset      (i_reset),
        .i_en         (i_a_en),
        .i_we         (i_a_we),
        .i_addr       (i_a_addr),
        .i_din        (i_a_din),
        .i_addr_latch (i_a_addr_latch),
        .i_out_reg    (i_a_out_reg),
        .i_wmode      (i_a_wmode),
        .i_split      (i_split),
        .i_cas_en     (i_a_cas_en),
        .i_sleep      (i_sleep),
        .i_cas_din    (i_a_cas_din),
        .o_dout       (o_a_dout),
        .o_cas_dout   (o_a_cas_dout),
        .mem          (mem_a.port_side)
    );

    dpbr_port #(
        .PORT_HALF (1'b1)
    ) u_port_b (
        .i_clk        (i_clk),
        .i_reset      (i_reset),
        .i_en         (i_b_en),
        .i_we         (i_b_we),
        .i_addr       (i_b_addr),
        .i_din        (i_b_din),
        .i_addr_latch (i_b_addr_latch),
        .i_out_reg    (i_b_out_reg),
        .i_wmode      (i_b_wmode),
        .i_split      (i_split),
        .i_cas_en     (i_b_cas_en),
        .i_sleep      (i_sleep),
        .i_cas_din    (i_b_cas_din),
        .o_dout       (o_b_dout),
        .o_cas_dout   (o_b_cas_dout),
        .mem          (mem_b.port_side)
    );

    // Read ports see the word before this edge's write, which gives read-first data.
    assign mem_a.rd_data = store[mem_a.req_addr];
    assign mem_b.rd_data = store[mem_b.req_addr];

    // Writes land on the clock edge; the contents hold while gated for power.
    // A same-address write from both ports is left to port B, the data is undefined anyway.
    always_ff @(posedge i_clk) begin
        if (mem_a.req_en && mem_a.req_we) begin
            store[mem_a.req_addr] <= mem_a.req_din;
        end
        if (mem_b.req_en && mem_b.req_we) begin
            store[mem_b.req_addr] <= mem_b.req_din;
        end
    end

endmodule : dpbr_top

`default_nettype wire

// *** tb/dpbr_nbr.sv ***
`timescale 1ns/1ps
`default_nettype none

module dpbr_nbr #(
    parameter logic [35:0] PAT = 36'h5A5A5A5A5
) (
    input  wire logic                              i_clk,
    input  wire logic                              i_reset,
    input  wire logic                              i_en,
    input  wire logic [dpbr_pkg::DPBR_PADDR_W-1:0] i_addr,
    output logic      [dpbr_pkg::DPBR_DATA_W-1:0]  o_rd
);
    import dpbr_pkg::*;
    // When not selected the output flips every cycle, so stale data never looks valid.
    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rd <= DPBR_DATA_RST;
        end else if (i_en && i_addr[DPBR_CAS_BIT]) begin
            o_rd <= PAT ^ DPBR_DATA_W'(i_addr[DPBR_ADDR_W-1:0]);
        end else begin
            o_rd <= ~o_rd;
        end
    end
endmodule : dpbr_nbr

`default_nettype wire

// *** tb/dpbr_checker.sv ***
`timescale 1ns/1ps
`default_nettype none

module dpbr_checker (
    input wire logic                              i_clk,
    input wire logic                              i_reset,
    input wire logic                              i_sleep,
    input wire logic                              i_a_en,
    input wire logic                              i_a_we,
    input wire logic [dpbr_pkg::DPBR_PADDR_W-1:0] i_a_addr,
    input wire logic [dpbr_pkg::DPBR_DATA_W-1:0]  i_a_din,
    input wire logic                              i_a_out_reg,
    input wire dpbr_pkg::dpbr_wmode_t             i_a_wmode,
    input wire logic                              i_b_en,
    input wire logic                              i_b_we,
    input wire logic [dpbr_pkg::DPBR_PADDR_W-1:0] i_b_addr,
    input wire logic                              i_b_out_reg,
    input wire logic                              i_b_cas_en,
    input wire logic [dpbr_pkg::DPBR_DATA_W-1:0]  i_b_cas_din,
    input wire logic [dpbr_pkg::DPBR_DATA_W-1:0]  o_a_dout,
    input wire logic [dpbr_pkg::DPBR_DATA_W-1:0]  o_b_dout
);
    import dpbr_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence s_wr_a(m);
        i_a_en && i_a_we && !i_sleep && !i_a_addr[DPBR_CAS_BIT] && i_a_wmode == m;
    endsequence
    sequence s_cas_rd_b;
        i_b_en && !i_b_we && !i_sleep && i_b_cas_en && i_b_addr[DPBR_CAS_BIT] && !i_b_out_reg;
    endsequence
    chk_rst_zero: assert property (
        $fell(i_reset) |-> o_a_dout == DPBR_DATA_RST && o_b_dout == DPBR_DATA_RST)
        else $error("outputs not zero after reset");
    chk_hold_idle_a: assert property (
        !$past(i_a_en, 2) && !$past(i_a_en, 3) && $stable(i_a_out_reg) |-> $stable(o_a_dout))
        else $error("port A output moved while idle");
    chk_hold_idle_b: assert property (
        !$past(i_b_en, 2) && !$past(i_b_en, 3) |-> $stable(o_b_dout))
        else $error("port B output moved while idle");
    chk_sleep_hold: assert property (
        i_sleep [*3] |=> $stable(o_a_dout) && $stable(o_b_dout))
        else $error("output moved while sleeping");
    chk_wfirst_a: assert property (
        s_wr_a(DPBR_WM_WRITE_FIRST) ##0 !i_a_out_reg [*3] |-> o_a_dout == $past(i_a_din, 2))
        else $error("write-first output wrong");
    chk_nochg_a: assert property (
        s_wr_a(DPBR_WM_NO_CHANGE) ##0 !i_a_out_reg [*3] |-> $stable(o_a_dout))
        else $error("no-change write moved output");
    chk_pipe_a: assert property (
        s_wr_a(DPBR_WM_WRITE_FIRST) ##0 i_a_out_reg [*4] |-> o_a_dout == $past(i_a_din, 3))
        else $error("pipelined output wrong");
    chk_cas_b: assert property (
        s_cas_rd_b |-> ##2 o_b_dout == $past(i_b_cas_din))
        else $error("cascade read wrong");
endmodule : dpbr_checker

bind dpbr_top dpbr_checker u_dpbr_checker (.i_clk, .i_reset, .i_sleep, .i_a_en, .i_a_we,
    .i_a_addr, .i_a_din, .i_a_out_reg, .i_a_wmode, .i_b_en, .i_b_we, .i_b_addr,
    .i_b_out_reg, .i_b_cas_en, .i_b_cas_din, .o_a_dout, .o_b_dout);

`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import dpbr_pkg::*;
    localparam logic [35:0] NB_PAT = 36'h5A5A5A5A5;
    logic i_clk = 1'b0, i_reset = 1'b1, i_split = 1'b0, i_sleep = 1'b0;
    logic i_a_en = 1'b0, i_a_we = 1'b0, i_a_addr_latch = 1'b1, i_a_out_reg = 1'b0;
    logic i_b_en = 1'b0, i_b_we = 1'b0, i_b_addr_latch = 1'b1, i_b_out_reg = 1'b0;
    logic i_a_cas_en = 1'b0, i_b_cas_en = 1'b0;
    logic [DPBR_PADDR_W-1:0] i_a_addr = 11'h000, i_b_addr = 11'h000;
    logic [DPBR_DATA_W-1:0]  i_a_din = 36'h0, i_b_din = 36'h0;
    dpbr_wmode_t             i_a_wmode = DPBR_WM_WRITE_FIRST, i_b_wmode = DPBR_WM_WRITE_FIRST;
    wire logic [DPBR_DATA_W-1:0] o_a_dout, o_b_dout, o_a_cas_dout, o_b_cas_dout, i_b_cas_din;
    int fails = 0, n_tests = 0;

    dpbr_top u_dpbr_top (.i_clk, .i_reset, .i_split, .i_sleep, .i_a_en, .i_a_we, .i_a_addr,
        .i_a_din, .i_a_addr_latch, .i_a_out_reg, .i_a_wmode, .i_a_cas_en,
        .i_a_cas_din(o_b_cas_dout), .o_a_dout, .o_a_cas_dout, .i_b_en, .i_b_we, .i_b_addr,
        .i_b_din, .i_b_addr_latch, .i_b_out_reg, .i_b_wmode, .i_b_cas_en, .i_b_cas_din,
        .o_b_dout, .o_b_cas_dout);
    dpbr_nbr #(.PAT(NB_PAT)) u_dpbr_nbr (.i_clk, .i_reset, .i_en(i_b_en & i_b_cas_en),
        .i_addr(i_b_addr), .o_rd(i_b_cas_din));

    always #2.5 i_clk = ~i_clk;

    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic op(input logic p, input logic we, input logic [10:0] ad, input logic [35:0] d);
        @(negedge i_clk);
        if (p) begin
            {i_b_en, i_b_we, i_b_addr, i_b_din} = {1'b1, we, ad, d};
        end else begin
            {i_a_en, i_a_we, i_a_addr, i_a_din} = {1'b1, we, ad, d};
        end
        @(negedge i_clk);
        i_a_en = 1'b0;
        i_b_en = 1'b0;
    endtask : op
    task automatic xfer(input logic p, input logic we, input logic [10:0] ad,
                        input logic [35:0] d, input logic [35:0] exp);
        op(p, we, ad, d);
        repeat (1 + (p ? i_b_out_reg : i_a_out_reg)) @(negedge i_clk);
        chk(p ? o_b_dout : o_a_dout, exp);
    endtask : xfer
    task automatic t_wmodes;
        dpbr_wmode_t m [4] = '{DPBR_WM_WRITE_FIRST, DPBR_WM_READ_FIRST, DPBR_WM_NO_CHANGE,
                               DPBR_WM_WRITE_FIRST};
        logic [35:0] e [4] = '{36'h1, 36'h1, 36'h1, 36'h4};
        for (int i = 0; i < 4; i++) begin
            i_a_wmode = m[i];
            xfer(1'b0, 1'b1, 11'h005, 36'(i + 1), e[i]);
        end
        xfer(1'b0, 1'b0, 11'h005, 36'h0, 36'h4);
    endtask : t_wmodes
    task automatic t_ports;
        xfer(1'b1, 1'b0, 11'h005, 36'h0, 36'h4);
        i_split = 1'b1;
        xfer(1'b0, 1'b1, 11'h005, 36'hA, 36'hA);
        xfer(1'b1, 1'b1, 11'h005, 36'hB, 36'hB);
        xfer(1'b0, 1'b0, 11'h005, 36'h0, 36'hA);
        i_split = 1'b0;
        xfer(1'b0, 1'b0, 11'h205, 36'h0, 36'hB);
    endtask : t_ports
    task automatic t_pipe;
        i_a_out_reg = 1'b1;
        xfer(1'b0, 1'b0, 11'h005, 36'h0, 36'hA);
        op(1'b0, 1'b1, 11'h006, 36'hC);
        @(negedge i_clk);
        chk(o_a_dout, 36'hA);
        @(negedge i_clk);
        chk(o_a_dout, 36'hC);
        // Keep the pipeline on through the edge at which the pipelined write is judged.
        @(negedge i_clk);
        i_a_out_reg = 1'b0;
    endtask : t_pipe
    task automatic t_latch;
        xfer(1'b0, 1'b0, 11'h006, 36'h0, 36'hC);
        i_a_addr_latch = 1'b0;
        xfer(1'b0, 1'b0, 11'h205, 36'h0, 36'hC);
        i_a_addr_latch = 1'b1;
        repeat (4) @(negedge i_clk);
        chk(o_a_dout, 36'hC);
    endtask : t_latch
    task automatic t_sleep;
        i_sleep = 1'b1;
        xfer(1'b0, 1'b1, 11'h006, 36'hD, 36'hC);
        i_sleep = 1'b0;
        xfer(1'b0, 1'b0, 11'h006, 36'h0, 36'hC);
    endtask : t_sleep
    task automatic t_cas;
        i_b_cas_en = 1'b1;
        xfer(1'b1, 1'b0, 11'h405, 36'h0, NB_PAT ^ 36'h005);
        op(1'b1, 1'b1, 11'h405, 36'hE);
        // The cascade select must still stand at the access edge after capture.
        @(negedge i_clk);
        i_b_cas_en = 1'b0;
        xfer(1'b1, 1'b0, 11'h005, 36'h0, 36'hA);
        i_a_cas_en = 1'b1;
        xfer(1'b0, 1'b0, 11'h405, 36'h0, 36'hA);
        chk(o_a_cas_dout, 36'hC);
        i_a_cas_en = 1'b0;
    endtask : t_cas
    task automatic end_sim;
        $display("tests=%0d fails=%0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_sim

    initial begin
        repeat (20) @(negedge i_clk);
        i_reset = 1'b0;
        chk(o_a_dout, DPBR_DATA_RST);
        chk(o_b_dout, DPBR_DATA_RST);
        t_wmodes();
        t_ports();
        t_pipe();
        t_latch();
        t_sleep();
        t_cas();
        end_sim();
    end
    initial begin
        #20000;
        fails++;
        end_sim();
    end
endmodule : testbench

`default_nettype wire
